// [hdl/serial_cfg_pkg.sv]
package serial_cfg_pkg;

  // Frame layout shared by both framings.
  localparam int FRAME_BITS   = 32;
  localparam int DATA_W       = 24;
  localparam int LEG_ADDR_W   = 6;
  localparam int REG_ADDR_W   = 5;
  localparam int CHIP_W       = 3;
  localparam int EDGE_W       = 6;

  // Edge numbers within a frame, counted from one.
  localparam logic [EDGE_W-1:0] LEG_ADDR_DONE  = 6'h07;
  localparam logic [EDGE_W-1:0] LEG_COMMIT     = 6'h20;
  localparam logic [EDGE_W-1:0] ADR_DATA_LAST  = 6'h18;
  localparam logic [EDGE_W-1:0] ADR_FRAME_LAST = 6'h20;

  // Chip address this device answers to in addressed mode.
  localparam logic [CHIP_W-1:0] OWN_CHIP = 3'h0;
  // Register zero: identity on read, read pointer on addressed write.
  localparam logic [LEG_ADDR_W-1:0] REG_ZERO = 6'h00;
  // Identity word; the value is arbitrary.
  localparam logic [DATA_W-1:0] CHIP_ID = 24'h5A0C31;

  // Host timing, in nanoseconds and then in 125 MHz cycles.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_MAX_MHZ   = 50;
  localparam int CLK_MHZ       = 125;
  localparam int T_SETUP_NS    = 8;
  localparam int T_TAIL_NS     = 10;
  localparam int T_EN_HIGH_NS  = 10;
  localparam int T_EN_LOW_NS   = 20;
  localparam int SCK_HALF =
    (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAIL_CYC   = (T_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_HIGH_CYC = (T_EN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_LOW_CYC = (T_EN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W     = 4;

  // Host sequencer states, Gray coded along the addressed frame; the legacy step from H_TAIL to H_GAP flips two bits.
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_SHIFT = 3'h3,
    H_TAIL  = 3'h2,
    H_PULSE = 3'h6,
    H_GAP   = 3'h7
  } host_state_t;

endpackage : serial_cfg_pkg

// [hdl/serial_cfg_if.sv]
`timescale 1ns/1ps
interface serial_cfg_if;
  logic frameEnable;
  logic serialClock;
  logic serialDataIn;
  logic lockStatusOrReadOut;

  modport device (
    input  frameEnable,
    input  serialClock,
    input  serialDataIn,
    output lockStatusOrReadOut
  );

  modport host (
    output frameEnable,
    output serialClock,
    output serialDataIn,
    input  lockStatusOrReadOut
  );
endinterface : serial_cfg_if

// [hdl/serial_cfg_device.sv]
// Behaviour
// - Legacy write: enable high, data low, clock.
// - First rising edge samples read/write bit.
// - Legacy address bits on edges two-seven.
// - Legacy data bits on edges eight-thirtyone.
// - Legacy write commits on edge thirty-two.
// - Host waits, then drops enable after write.
// - First sample high means legacy read.
// - Lock status valid only while enable low.
// - Legacy read drives 24 bits, edges 8-31.
// - Host captures read bits on falling edges; this host samples them at the next rising edge.
// - Pin returns to lock on edge 32.
// - Enable falling ends legacy frame.
// - Serial clock never above 50 MHz.
// - Addressed frame: 24 data bits first.
// - Then 5-bit register address, edges 25-29.
// - Then 3-bit chip address, edges 30-32.
// - Answer only chip address zero.
// - Enable rise latches addressed frame.
// - Read data shifts out during addressed frame.
// - Write-only use needs three wires.
// - First edge after power-up fixes mode.
// - Register zero selects next frame's read-back.
`timescale 1ns/1ps
module serial_cfg_device
  import serial_cfg_pkg::*;
(
  serial_cfg_if.device             link,
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                lockIndicator,
  output logic                     writeValid,
  output logic [LEG_ADDR_W-1:0]    writeAddr,
  output logic [DATA_W-1:0]        writeData,
  output logic                     legacyMode,
  output logic                     modeDecided
);

  // Returns the word a read of the given register shows.
  function automatic logic [DATA_W-1:0] regView(
    input logic [LEG_ADDR_W-1:0] addr,
    input logic [DATA_W-1:0]     stored
  );
    regView = (addr == REG_ZERO) ? CHIP_ID : stored;
  endfunction : regView

  logic [DATA_W-1:0]      regFile [2**LEG_ADDR_W];
  logic [EDGE_W-1:0]      edgeCntQ;
  logic [FRAME_BITS-1:0]  shiftQ;
  logic                   decidedQ;
  logic                   legacyQ;
  logic                   readDriveQ;
  logic [DATA_W-1:0]      outShiftQ;
  logic [REG_ADDR_W-1:0]  readPtrQ;
  logic                   seenToggleQ;
  logic                   legToggleQ;
  logic [LEG_ADDR_W-1:0]  legAddrQ;
  logic [DATA_W-1:0]      legDataQ;
  logic [FRAME_BITS-1:0]  holdWordQ;
  logic                   holdToggleQ;
  logic                   frameClear;
  logic                   pending;
  logic [REG_ADDR_W-1:0]  pendAddr;
  logic [REG_ADDR_W-1:0]  effPtr;
  logic [DATA_W-1:0]      effWord;
  logic                   lockMetaQ;
  logic                   lockQ;
  logic [1:0]             legSyncQ;
  logic [1:0]             adrSyncQ;
  logic                   legSeenQ;
  logic                   adrSeenQ;
  logic                   dcdSync0Q;
  logic                   dcdSync1Q;
  logic                   legSync0Q;
  logic                   legSync1Q;

  // The frame is closed by the enable level itself, since the serial
  // clock stops between frames and no edge would arrive to end it.
  // Legacy frames end when enable falls, addressed ones when it rises.
  assign frameClear = !reset_n
                    || (decidedQ && (legacyQ ? !link.frameEnable
                                             : link.frameEnable));

  // Mode is fixed by the first edge: enable already high at the first
  // clock rise means enable rose first. Only power-up reset undoes it.
  always_ff @(posedge link.serialClock or negedge reset_n) begin
    if (!reset_n) begin
      decidedQ <= 1'b0;
      legacyQ  <= 1'b0;
    end else if (!decidedQ) begin
      decidedQ <= 1'b1;
      legacyQ  <= link.frameEnable;
    end
  end

  // Rising edges are counted from one; the count saturates at 32.
  always_ff @(posedge link.serialClock or posedge frameClear) begin
    if (frameClear) begin
      edgeCntQ <= '0;
    end else if (edgeCntQ != LEG_COMMIT) begin
      edgeCntQ <= edgeCntQ + 6'h01;
    end
  end

  // Input bits shift in MSB first on every rising edge of a frame.
  always_ff @(posedge link.serialClock) begin
    if (edgeCntQ != ADR_FRAME_LAST) begin
      shiftQ <= {shiftQ[FRAME_BITS-2:0], link.serialDataIn};
    end
  end

  // A latched addressed frame not yet applied to the register file.
  assign pending  = holdToggleQ != seenToggleQ;
  assign pendAddr = holdWordQ[CHIP_W +: REG_ADDR_W];

  // Read pointer seen by the frame after a register-zero write, with the
  // pending frame's data bypassed so read-back needs no extra frame.
  always_comb begin
    effPtr  = readPtrQ;
    if (pending && pendAddr == REG_ZERO[REG_ADDR_W-1:0]) begin
      effPtr = holdWordQ[CHIP_W + REG_ADDR_W +: REG_ADDR_W];
    end
    effWord = regView({1'b0, effPtr}, regFile[{1'b0, effPtr}]);
    if (pending && pendAddr == effPtr && effPtr != '0) begin
      effWord = holdWordQ[FRAME_BITS-1 -: DATA_W];
    end
  end

  // Register file and read pointer, written only on serial clock edges.
  // An addressed frame is applied at the first edge of the next frame.
  always_ff @(posedge link.serialClock) begin
    if (decidedQ && legacyQ && edgeCntQ == LEG_COMMIT - 6'h01
        && !shiftQ[FRAME_BITS-2]) begin
      if (shiftQ[DATA_W +: LEG_ADDR_W] != REG_ZERO) begin
        regFile[shiftQ[DATA_W +: LEG_ADDR_W]] <= shiftQ[DATA_W-1:0];
      end
    end
    if (decidedQ && !legacyQ && edgeCntQ == '0 && pending
        && pendAddr != REG_ZERO[REG_ADDR_W-1:0]) begin
      regFile[{1'b0, pendAddr}] <= holdWordQ[FRAME_BITS-1 -: DATA_W];
    end
  end

  // Apply marker and read pointer are reset, so that the pending flag
  // starts known; an unknown marker would block every addressed write.
  always_ff @(posedge link.serialClock or negedge reset_n) begin
    if (!reset_n) begin
      seenToggleQ <= 1'b0;
      readPtrQ    <= '0;
    end else if (decidedQ && !legacyQ && edgeCntQ == '0 && pending) begin
      seenToggleQ <= holdToggleQ;
      if (pendAddr == REG_ZERO[REG_ADDR_W-1:0]) begin
        readPtrQ <= holdWordQ[CHIP_W + REG_ADDR_W +: REG_ADDR_W];
      end
    end
  end

  // Legacy commit record handed to the system side by a toggle.
  always_ff @(posedge link.serialClock or negedge reset_n) begin
    if (!reset_n) begin
      legToggleQ <= 1'b0;
      legAddrQ   <= '0;
      legDataQ   <= '0;
    end else if (decidedQ && legacyQ && edgeCntQ == LEG_COMMIT - 6'h01
                 && !shiftQ[FRAME_BITS-2]) begin
      legToggleQ <= !legToggleQ;
      legAddrQ   <= shiftQ[DATA_W +: LEG_ADDR_W];
      legDataQ   <= shiftQ[DATA_W-1:0];
    end
  end

  // The addressed frame is taken on the enable rise itself, because
  // no serial clock edge follows it; a foreign chip address is dropped.
  always_ff @(posedge link.frameEnable or negedge reset_n) begin
    if (!reset_n) begin
      holdToggleQ <= 1'b0;
      holdWordQ   <= '0;
    end else if (decidedQ && !legacyQ && edgeCntQ == ADR_FRAME_LAST
                 && shiftQ[CHIP_W-1:0] == OWN_CHIP) begin
      holdToggleQ <= !holdToggleQ;
      holdWordQ   <= shiftQ;
    end
  end

  // Read-out shifter. Legacy reads load at edge 8 and stop at edge 32;
  // addressed frames load at edge 1 and stop at edge 25.
  always_ff @(posedge link.serialClock or posedge frameClear) begin
    if (frameClear) begin
      readDriveQ <= 1'b0;
      outShiftQ  <= '0;
    end else if (decidedQ ? !legacyQ : !link.frameEnable) begin
      if (edgeCntQ == '0) begin
        readDriveQ <= 1'b1;
        outShiftQ  <= effWord;
      end else if (edgeCntQ == ADR_DATA_LAST) begin
        readDriveQ <= 1'b0;
      end else begin
        outShiftQ  <= {outShiftQ[DATA_W-2:0], 1'b0};
      end
    end else if (edgeCntQ == LEG_ADDR_DONE && shiftQ[LEG_ADDR_W]) begin
      readDriveQ <= 1'b1;
      outShiftQ  <= regView(shiftQ[LEG_ADDR_W-1:0],
                            regFile[shiftQ[LEG_ADDR_W-1:0]]);
    end else if (edgeCntQ == LEG_COMMIT - 6'h01) begin
      readDriveQ <= 1'b0;
    end else begin
      outShiftQ  <= {outShiftQ[DATA_W-2:0], 1'b0};
    end
  end

  // The shared pin shows read data while the shifter drives, lock
  // status otherwise; both sources are flip-flops.
  assign link.lockStatusOrReadOut = readDriveQ ? outShiftQ[DATA_W-1] : lockQ;

  // The lock indicator comes from a pin, so it passes two flip-flops.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lockMetaQ <= 1'b0;
      lockQ     <= 1'b0;
    end else begin
      lockMetaQ <= lockIndicator;
      lockQ     <= lockMetaQ;
    end
  end

  // Two-stage synchronisers for the commit toggles and mode flags.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      legSyncQ  <= '0;
      adrSyncQ  <= '0;
      dcdSync0Q <= 1'b0;
      dcdSync1Q <= 1'b0;
      legSync0Q <= 1'b0;
      legSync1Q <= 1'b0;
    end else begin
      legSyncQ  <= {legSyncQ[0], legToggleQ};
      adrSyncQ  <= {adrSyncQ[0], holdToggleQ};
      dcdSync0Q <= decidedQ;
      dcdSync1Q <= dcdSync0Q;
      legSync0Q <= legacyQ;
      legSync1Q <= legSync0Q;
    end
  end

  // Commit words stay stable for a whole frame after their toggle, so
  // they are sampled directly once the toggle has been synchronised.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      legSeenQ    <= 1'b0;
      adrSeenQ    <= 1'b0;
      writeValid  <= 1'b0;
      writeAddr   <= '0;
      writeData   <= '0;
      legacyMode  <= 1'b0;
      modeDecided <= 1'b0;
    end else begin
      legSeenQ    <= legSyncQ[1];
      adrSeenQ    <= adrSyncQ[1];
      modeDecided <= dcdSync1Q;
      legacyMode  <= legSync1Q;
      writeValid  <= 1'b0;
      if (legSyncQ[1] != legSeenQ) begin
        writeValid <= 1'b1;
        writeAddr  <= legAddrQ;
        writeData  <= legDataQ;
      end else if (adrSyncQ[1] != adrSeenQ) begin
        writeValid <= 1'b1;
        writeAddr  <= {1'b0, holdWordQ[CHIP_W +: REG_ADDR_W]};
        writeData  <= holdWordQ[FRAME_BITS-1 -: DATA_W];
      end
    end
  end

endmodule : serial_cfg_device

// [hdl/serial_cfg_host.sv]
`timescale 1ns/1ps
module serial_cfg_host
  import serial_cfg_pkg::*;
(
  serial_cfg_if.host               link,
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                startValid,
  input  wire logic                startLegacy,
  input  wire logic                startRead,
  input  wire logic [LEG_ADDR_W-1:0] startAddr,
  input  wire logic [DATA_W-1:0]   startData,
  input  wire logic [CHIP_W-1:0]   startChip,
  output logic                     busy,
  output logic                     doneValid,
  output logic [DATA_W-1:0]        readData
);

  host_state_t            stateQ;
  logic [WAIT_W-1:0]      waitQ;
  logic [WAIT_W-1:0]      halfQ;
  logic [EDGE_W-1:0]      edgeQ;
  logic [FRAME_BITS-1:0]  frameQ;
  logic                   sclkQ;
  logic                   enableQ;
  logic                   legacyQ;
  logic                   readQ;
  logic                   pinSync0Q;
  logic                   pinSync1Q;
  logic                   capture;

  assign link.serialClock  = sclkQ;
  assign link.frameEnable  = enableQ;
  assign link.serialDataIn = frameQ[FRAME_BITS-1];

  // The read pin comes from the device's clock domain.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pinSync0Q <= 1'b0;
      pinSync1Q <= 1'b0;
    end else begin
      pinSync0Q <= link.lockStatusOrReadOut;
      pinSync1Q <= pinSync0Q;
    end
  end

  // Data launched at one rise is taken just before the next rise,
  // late in the low phase, which covers the synchroniser delay.
  assign capture = legacyQ ? (readQ && edgeQ > LEG_ADDR_DONE
                              && edgeQ < LEG_COMMIT)
                           : (edgeQ != '0 && edgeQ <= ADR_DATA_LAST);

  // Frame sequencer. The serial clock is the system clock divided so
  // that its period never drops below 20 ns.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stateQ    <= H_IDLE;
      waitQ     <= '0;
      halfQ     <= '0;
      edgeQ     <= '0;
      frameQ    <= '0;
      sclkQ     <= 1'b0;
      enableQ   <= 1'b0;
      legacyQ   <= 1'b0;
      readQ     <= 1'b0;
      busy      <= 1'b0;
      doneValid <= 1'b0;
      readData  <= '0;
    end else begin
      doneValid <= 1'b0;
      unique case (stateQ)
        H_IDLE: begin
          if (startValid) begin
            busy    <= 1'b1;
            legacyQ <= startLegacy;
            readQ   <= startRead;
            edgeQ   <= '0;
            halfQ   <= '0;
            waitQ   <= WAIT_W'(SETUP_CYC);
            enableQ <= startLegacy;
            if (startLegacy) begin
              frameQ <= {startRead, startAddr, startData, 1'b0};
            end else begin
              frameQ <= {startData, startAddr[REG_ADDR_W-1:0],
                         startChip};
            end
            stateQ  <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (waitQ <= WAIT_W'(1)) begin
            stateQ <= H_SHIFT;
          end else begin
            waitQ <= waitQ - WAIT_W'(1);
          end
        end
        H_SHIFT: begin
          if (halfQ == WAIT_W'(SCK_HALF - 1)) begin
            halfQ <= '0;
            sclkQ <= !sclkQ;
            if (!sclkQ) begin
              edgeQ <= edgeQ + 6'h01;
              if (capture) begin
                readData <= {readData[DATA_W-2:0], pinSync1Q};
              end
            end else if (edgeQ == LEG_COMMIT) begin
              waitQ  <= WAIT_W'(TAIL_CYC);
              stateQ <= H_TAIL;
            end else begin
              frameQ <= {frameQ[FRAME_BITS-2:0], 1'b0};
            end
          end else begin
            halfQ <= halfQ + WAIT_W'(1);
          end
        end
        H_TAIL: begin
          if (waitQ <= WAIT_W'(1)) begin
            if (legacyQ) begin
              enableQ <= 1'b0;
              waitQ   <= WAIT_W'(EN_LOW_CYC);
              stateQ  <= H_GAP;
            end else begin
              enableQ <= 1'b1;
              waitQ   <= WAIT_W'(EN_HIGH_CYC);
              stateQ  <= H_PULSE;
            end
          end else begin
            waitQ <= waitQ - WAIT_W'(1);
          end
        end
        H_PULSE: begin
          if (waitQ <= WAIT_W'(1)) begin
            enableQ <= 1'b0;
            waitQ   <= WAIT_W'(EN_LOW_CYC);
            stateQ  <= H_GAP;
          end else begin
            waitQ <= waitQ - WAIT_W'(1);
          end
        end
        H_GAP: begin
          if (waitQ <= WAIT_W'(1)) begin
            busy      <= 1'b0;
            doneValid <= 1'b1;
            stateQ    <= H_IDLE;
          end else begin
            waitQ <= waitQ - WAIT_W'(1);
          end
        end
        default: begin
          stateQ <= H_IDLE;
        end
      endcase
    end
  end

endmodule : serial_cfg_host

// [tb/serial_cfg_assertions.sv]
`timescale 1ns/1ps
module serial_cfg_assertions (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic frameEnable,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic lockStatusOrReadOut
);
  logic       sckPrev_q;
  logic       enPrev_q;
  logic       known_q;
  logic       legacy_q;
  logic [5:0] riseCnt_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Previous levels of the link lines, for edge detection.
  always_ff @(posedge clock) begin
    sckPrev_q <= reset_n & serialClock;
    enPrev_q  <= reset_n & frameEnable;
  end

  // The mode is taken at the first serial clock rise, as the device must.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      known_q  <= 1'b0;
      legacy_q <= 1'b0;
    end else if (!known_q && serialClock && !sckPrev_q) begin
      known_q  <= 1'b1;
      legacy_q <= frameEnable;
    end
  end

  // Rises per frame; the count clears where the next frame opens in each mode.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      riseCnt_q <= 6'h00;
    end else if (serialClock && !sckPrev_q) begin
      riseCnt_q <= riseCnt_q + 6'h01;
    end else if (legacy_q ? (frameEnable && !enPrev_q) : (!frameEnable && enPrev_q)) begin
      riseCnt_q <= 6'h00;
    end
  end

  a_sclk_high_half: assert property ($rose(serialClock) |=> serialClock ##1 !serialClock)
    else $error("serial clock high phase is not two cycles");
  a_sclk_low_half: assert property ($fell(serialClock) |-> ##1 !serialClock)
    else $error("serial clock low phase is shorter than two cycles");
  a_sdi_on_fall: assert property ($changed(serialDataIn) |-> !serialClock)
    else $error("serial data changed while serial clock was high");
  a_enable_setup: assert property ($rose(frameEnable) |-> !serialClock ##1 !serialClock)
    else $error("enable rose too close to a serial clock rise");
  a_clk_in_frame: assert property ($rose(serialClock) && known_q |-> frameEnable == legacy_q)
    else $error("serial clock rise outside the frame of the fixed mode");
  a_no_extra_rise: assert property ($rose(serialClock) |-> riseCnt_q < 6'h20)
    else $error("more than thirty-two rises in one frame");
  a_legacy_frame_len: assert property ($fell(frameEnable) && legacy_q |-> riseCnt_q == 6'h20)
    else $error("legacy frame ended without thirty-two rises");
  a_addr_frame_len: assert property ($rose(frameEnable) && known_q && !legacy_q
    |-> riseCnt_q == 6'h20)
    else $error("addressed latch pulse without thirty-two rises");
  a_legacy_tail: assert property ($rose(serialClock) && legacy_q && riseCnt_q == 6'h1F
    |-> frameEnable [*4])
    else $error("enable dropped too soon after the last rise");
  a_addr_pulse: assert property ($rose(frameEnable) && known_q && !legacy_q
    |-> ##1 frameEnable ##1 !frameEnable)
    else $error("addressed latch pulse is not two cycles");
  a_enable_gap: assert property ($fell(frameEnable) |-> ##1 !frameEnable ##1 !frameEnable)
    else $error("enable low time shorter than three cycles");

  // Main scenarios seen on the wire.
  cover property ($fell(frameEnable) && legacy_q);
  cover property ($rose(frameEnable) && known_q && !legacy_q);
  cover property (frameEnable && legacy_q && $changed(lockStatusOrReadOut));
endmodule : serial_cfg_assertions

// [tb/dual_mode_serial_config_port_test.sv]
`timescale 1ns/1ps
module dual_mode_serial_config_port_test;
  import serial_cfg_pkg::*;
  logic        clock;
  logic        reset_n;
  logic        lockIndicator;
  logic        startValid;
  logic        startLegacy;
  logic        startRead;
  logic [5:0]  startAddr;
  logic [23:0] startData;
  logic [2:0]  startChip;
  logic        busy;
  logic        doneValid;
  logic [23:0] readData;
  logic        writeValid;
  logic [5:0]  writeAddr;
  logic [23:0] writeData;
  logic        legacyMode;
  logic        modeDecided;
  logic [5:0]  lastAddr;
  logic [23:0] lastData;
  int          n_mismatch = 0;
  int          checked = 0;
  int          wrCount = 0;

  serial_cfg_if linkIf ();
  serial_cfg_host serial_cfg_host_inst (.link(linkIf), .clock(clock), .reset_n(reset_n),
    .startValid(startValid), .startLegacy(startLegacy), .startRead(startRead),
    .startAddr(startAddr), .startData(startData), .startChip(startChip), .busy(busy),
    .doneValid(doneValid), .readData(readData));
  serial_cfg_device serial_cfg_device_inst (.link(linkIf), .clock(clock), .reset_n(reset_n),
    .lockIndicator(lockIndicator), .writeValid(writeValid), .writeAddr(writeAddr),
    .writeData(writeData), .legacyMode(legacyMode), .modeDecided(modeDecided));
  serial_cfg_assertions serial_cfg_assertions_inst (.clock(clock), .reset_n(reset_n),
    .frameEnable(linkIf.frameEnable), .serialClock(linkIf.serialClock),
    .serialDataIn(linkIf.serialDataIn), .lockStatusOrReadOut(linkIf.lockStatusOrReadOut));

  // The clock runs free at 125 MHz.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Every committed write is recorded so that refused frames show up as a missing count.
  always @(posedge clock) begin
    if (writeValid === 1'b1) begin
      wrCount  <= wrCount + 1;
      lastAddr <= writeAddr;
      lastData <= writeData;
    end
  end

  task automatic compare(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  // Reset also acts as power-up for the link side, so the mode may be chosen again.
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    #1 reset_n = 1'b1;
  endtask : do_reset

  // One whole frame from the host user port, waited for under a bound.
  task automatic frame(input logic leg, input logic rd, input logic [5:0] a,
                       input logic [23:0] d, input logic [2:0] c);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    {startLegacy, startRead, startAddr, startData, startChip} = {leg, rd, a, d, c};
    startValid = 1'b1;
    @(posedge clock);
    #1 startValid = 1'b0;
    compare("busy", 24'h000001, {23'h0, busy});
    while (doneValid !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 400) begin
      n_mismatch++;
      $display("Error doneValid expected 1 seen 0");
    end
    // The device commit pulse comes a few cycles before the host's done.
    repeat (8) @(posedge clock);
    #1;
    compare("busy", 24'h000000, {23'h0, busy});
  endtask : frame

  task automatic lock_check(input logic v);
    lockIndicator = v;
    repeat (4) @(posedge clock);
    #1 compare("lock pin", {23'h0, v}, {23'h0, linkIf.lockStatusOrReadOut});
  endtask : lock_check

  task automatic test_legacy;
    int w;
    do_reset();
    w = wrCount;
    lock_check(1'b1);
    lock_check(1'b0);
    frame(1'b1, 1'b0, 6'h05, 24'hA5C3E1, 3'h0);
    compare("write count", 24'(w + 1), 24'(wrCount));
    compare("write addr", 24'h000005, {18'h0, lastAddr});
    compare("write data", 24'hA5C3E1, lastData);
    compare("mode flags", 24'h000003, {22'h0, legacyMode, modeDecided});
    lock_check(1'b1);
    frame(1'b1, 1'b1, 6'h05, 24'h000000, 3'h0);
    compare("read data", 24'hA5C3E1, readData);
    compare("read count", 24'(w + 1), 24'(wrCount));
    lock_check(1'b1);
    frame(1'b1, 1'b0, 6'h3F, 24'h000001, 3'h0);
    frame(1'b1, 1'b1, 6'h3F, 24'h000000, 3'h0);
    compare("top reg read", 24'h000001, readData);
    frame(1'b1, 1'b1, REG_ZERO, 24'h000000, 3'h0);
    compare("identity read", CHIP_ID, readData);
    $display("test_legacy finished");
  endtask : test_legacy

  task automatic test_addressed;
    int w;
    do_reset();
    w = wrCount;
    frame(1'b0, 1'b0, 6'h03, 24'h3C5A96, 3'h0);
    compare("write count", 24'(w + 1), 24'(wrCount));
    compare("write addr", 24'h000003, {18'h0, lastAddr});
    compare("write data", 24'h3C5A96, lastData);
    compare("mode flags", 24'h000001, {22'h0, legacyMode, modeDecided});
    frame(1'b0, 1'b0, 6'h03, 24'h111111, 3'h1);
    compare("foreign count", 24'(w + 1), 24'(wrCount));
    frame(1'b0, 1'b0, REG_ZERO, 24'h000003, 3'h0);
    frame(1'b0, 1'b0, REG_ZERO, 24'h000003, 3'h0);
    compare("read back", 24'h3C5A96, readData);
    lock_check(1'b1);
    $display("test_addressed finished");
  endtask : test_addressed

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // A hang is cut short well beyond the roughly 1300 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    reset_n       = 1'b0;
    lockIndicator = 1'b0;
    startValid    = 1'b0;
    startLegacy   = 1'b0;
    startRead     = 1'b0;
    startAddr     = 6'h00;
    startData     = 24'h000000;
    startChip     = 3'h0;
    test_legacy();
    test_addressed();
    wrap_up();
  end
endmodule : dual_mode_serial_config_port_test
